// ==== include/pll_fanout_regs.svh ====
/*
 * Named constants of the clock fan-out control block: timing, loop limits and reset values.
 * Assumes a single 40 MHz system clock; included by bare name.
 */
`ifndef PLL_FANOUT_REGS_SVH
`define PLL_FANOUT_REGS_SVH

// ==========================================================================
// Timing
// ==========================================================================
`define CLK_PERIOD_PS      25000
`define STAB_TIME_US       50
// Least time rounds up to whole cycles
`define STAB_CYCLES        ((`STAB_TIME_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define REF_TIMEOUT        12'hFFF

// ==========================================================================
// Oscillator model
// ==========================================================================
`define VCO_PERIOD_RST     12'h010
`define VCO_PERIOD_MIN     12'h001
`define VCO_PERIOD_MAX     12'hFFE
`define DIV_RST            2'h3
`define BANK_WIDTH         3

`endif

// ==== include/pll_fanout_pkg.sv ====
/*
 * Types shared by the clock fan-out control block.
 * Assumes pll_fanout_regs.svh supplies the numeric constants.
 */
`include "pll_fanout_regs.svh"

package pll_fanout_pkg;

   // Levels and drive enables of one bank of three outputs
   typedef struct packed {
      logic [`BANK_WIDTH-1:0] level;
      logic [`BANK_WIDTH-1:0] drive;
   } bank_t;

   typedef enum logic [0:0] {
      ST_ACQUIRE = 1'b0,
      ST_LOCKED  = 1'b1
   } loop_state_t;

endpackage : pll_fanout_pkg

// ==== design/phase_divider.sv ====
/*
 * Programmable tick generator standing in for the oscillator.
 * Assumes period is at least one; bypassTick is used instead while bypass is high.
 */
`timescale 1ns/1ps

module phase_divider #(
   parameter int PERIOD_W = 12
) (
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire logic [PERIOD_W-1:0] period,
   input  wire logic                bypass,
   input  wire logic                bypassTick,
   output logic                     tick
);

   logic [PERIOD_W-1:0] count;

   // ========================================================================
   // Tick every period cycles
   // ========================================================================
   always_ff @(posedge ref_clk) begin
      if (rst || bypass) begin
         count <= '0;
      end else if (count >= period - PERIOD_W'(1)) begin
         count <= '0;
      end else begin
         count <= count + PERIOD_W'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tick <= 1'b0;
      end else if (bypass) begin
         tick <= bypassTick;
      end else begin
         tick <= (count >= period - PERIOD_W'(1));
      end
   end

endmodule : phase_divider

// ==== design/pll_clock_fanout_select.sv ====
/*
 * Digital control of a phase-locked clock fan-out driver with two banks of three outputs.
 * Assumes reference and feedback inputs synchronous to ref_clk and far slower than it,
 * and one output wired back to the feedback input on the board.
 */
// Overview of operation
// - Bank A runs at half or quarter oscillator rate by ratio select.
// - Bank B always runs at half the oscillator rate.
// - Ratio select picks 1x, 1/2x or 2x bank ratios to the reference.
// - Fed-back output is forced to the reference frequency.
// - Every output toggles from a divider, giving 50 percent duty.
// - Enable low drives all six outputs; high releases them all.
// - Enable falling restarts the stabilization interval.
// - Loop trims the oscillator until feedback edges meet reference edges.
// - Test low runs outputs through the loop; test high bypasses it.
// - Feeding back bank B: select high halves bank A.
// - Other configuration: select high doubles bank B relative to reference.
// - Select change, enable fall, power-up, reference return restart stabilization.
`timescale 1ns/1ps
`include "pll_fanout_regs.svh"

module pll_clock_fanout_select #(
   parameter int PERIOD_W    = 12,
   parameter int STAB_CYCLES = `STAB_CYCLES
) (
   input  wire logic          ref_clk,
   input  wire logic          rst,
   input  wire logic          referenceClockIn,
   input  wire logic          loopFeedbackIn,
   input  wire logic          ratioSelect,
   input  wire logic          outputEnableN,
   input  wire logic          testMode,
   input  wire logic          factoryClear,
   output pll_fanout_pkg::bank_t bankAOutputs,
   output pll_fanout_pkg::bank_t bankBOutputs,
   output logic               lockPending
);

   logic                        refPrev;
   logic                        fbPrev;
   logic                        selPrev;
   logic                        oeNPrev;
   logic                        testPrev;
   logic                        refRise;
   logic                        refFall;
   logic                        fbRise;
   logic [PERIOD_W-1:0]         refCount;
   logic [PERIOD_W-1:0]         refPeriod;
   logic                        refLost;
   logic [PERIOD_W-1:0]         vcoPeriod;
   logic                        vcoTick;
   logic [1:0]                  divCount;
   logic                        disturb;
   logic [31:0]                 stabCount;
   pll_fanout_pkg::loop_state_t loopState;
   pll_fanout_pkg::loop_state_t next_loopState;

   // ========================================================================
   // Input edge history
   // ========================================================================
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         refPrev  <= 1'b0;
         fbPrev   <= 1'b0;
         selPrev  <= 1'b0;
         oeNPrev  <= 1'b1;
         testPrev <= 1'b0;
      end else begin
         refPrev  <= referenceClockIn;
         fbPrev   <= loopFeedbackIn;
         selPrev  <= ratioSelect;
         oeNPrev  <= outputEnableN;
         testPrev <= testMode;
      end
   end

   assign refRise = referenceClockIn & ~refPrev;
   assign refFall = ~referenceClockIn & refPrev;
   assign fbRise  = loopFeedbackIn & ~fbPrev;

   // ========================================================================
   // Reference period measurement and loss detection
   // ========================================================================
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         refCount  <= '0;
         refPeriod <= '0;
      end else if (refRise) begin
         refCount  <= '0;
         refPeriod <= refCount;
      end else if (refCount != `REF_TIMEOUT) begin
         refCount  <= refCount + PERIOD_W'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         refLost <= 1'b1;
      end else if (refRise) begin
         refLost <= 1'b0;
      end else if (refCount == `REF_TIMEOUT) begin
         refLost <= 1'b1;
      end
   end

   // ========================================================================
   // Phase detector and oscillator trim
   // ========================================================================
   // Feedback edge early in the reference cycle lags: shorten; late one leads: lengthen.
   // Coincident edges hold the period. Outputs released means no feedback: hold too.
   always_ff @(posedge ref_clk) begin
      if (rst || factoryClear) begin
         vcoPeriod <= `VCO_PERIOD_RST;
      end else if (!testMode && !outputEnableN && fbRise && !refRise) begin
         if (refCount < (refPeriod >> 1)) begin
            if (vcoPeriod > `VCO_PERIOD_MIN) begin
               vcoPeriod <= vcoPeriod - PERIOD_W'(1);
            end
         end else begin
            if (vcoPeriod < `VCO_PERIOD_MAX) begin
               vcoPeriod <= vcoPeriod + PERIOD_W'(1);
            end
         end
      end
   end

   // Test high feeds reference edges straight into the divider chain
   phase_divider #(
      .PERIOD_W   (PERIOD_W)
   ) u_osc (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .period     (vcoPeriod),
      .bypass     (testMode),
      .bypassTick (refRise | refFall),
      .tick       (vcoTick)
   );

   // ========================================================================
   // Common divider chain
   // ========================================================================
   // Inverted count bits: both halves rise together on the 3 to 0 wrap.
   always_ff @(posedge ref_clk) begin
      if (rst || factoryClear) begin
         divCount <= `DIV_RST;
      end else if (vcoTick) begin
         divCount <= divCount + 2'h1;
      end
   end

   // ========================================================================
   // Output banks
   // ========================================================================
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bankAOutputs.level <= '0;
      end else if (ratioSelect) begin
         bankAOutputs.level <= {`BANK_WIDTH{~divCount[1]}};
      end else begin
         bankAOutputs.level <= {`BANK_WIDTH{~divCount[0]}};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bankBOutputs.level <= '0;
      end else begin
         bankBOutputs.level <= {`BANK_WIDTH{~divCount[0]}};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bankAOutputs.drive <= '0;
         bankBOutputs.drive <= '0;
      end else begin
         bankAOutputs.drive <= {`BANK_WIDTH{~outputEnableN}};
         bankBOutputs.drive <= {`BANK_WIDTH{~outputEnableN}};
      end
   end

   // ========================================================================
   // Stabilization tracking
   // ========================================================================
   assign disturb = (ratioSelect != selPrev)
                  | (oeNPrev & ~outputEnableN)
                  | (testPrev & ~testMode)
                  | (refLost & refRise);

   always_comb begin
      next_loopState = loopState;
      case (loopState)
         pll_fanout_pkg::ST_ACQUIRE: begin
            if (!disturb && stabCount == 32'h00000000) begin
               next_loopState = pll_fanout_pkg::ST_LOCKED;
            end
         end
         pll_fanout_pkg::ST_LOCKED: begin
            if (disturb) begin
               next_loopState = pll_fanout_pkg::ST_ACQUIRE;
            end
         end
         default: begin
            next_loopState = pll_fanout_pkg::ST_ACQUIRE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         loopState <= pll_fanout_pkg::ST_ACQUIRE;
      end else begin
         loopState <= next_loopState;
      end
   end

   // Power-up counts as a disturbance: reset loads the full interval.
   always_ff @(posedge ref_clk) begin
      if (rst || disturb) begin
         stabCount <= 32'(STAB_CYCLES - 1);
      end else if (stabCount != 32'h00000000) begin
         stabCount <= stabCount - 32'h00000001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lockPending <= 1'b1;
      end else begin
         lockPending <= (next_loopState == pll_fanout_pkg::ST_ACQUIRE);
      end
   end

endmodule : pll_clock_fanout_select

// ==== tb/pll_fanout_checker.sv ====
/* Port assertions for the clock fan-out block.
   Assumes binding onto pll_clock_fanout_select. */
`timescale 1ns/1ps

module pll_fanout_checker #(
   parameter int STAB_CYCLES = 20
) (
   input wire logic                  ref_clk,
   input wire logic                  rst,
   input wire logic                  ratioSelect,
   input wire logic                  outputEnableN,
   input wire logic                  testMode,
   input wire pll_fanout_pkg::bank_t bankAOutputs,
   input wire pll_fanout_pkg::bank_t bankBOutputs,
   input wire logic                  lockPending
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [1:0] selHist;
   int         pendRun;
   always_ff @(posedge ref_clk) selHist <= {selHist[0], ratioSelect};
   always_ff @(posedge ref_clk) pendRun <= lockPending ? pendRun + 1 : 0;

   // ==========================================================
   // Assertions
   // ==========================================================
   chk_drive_on: assert property ($fell(outputEnableN) |=>
      bankAOutputs.drive == 3'h7 && bankBOutputs.drive == 3'h7) else $error("drive not on");
   chk_drive_off: assert property ($rose(outputEnableN) |=>
      (bankAOutputs.drive | bankBOutputs.drive) == 3'h0) else $error("drive not off");
   chk_enable_restart: assert property ($fell(outputEnableN) |=> lockPending)
      else $error("no wait after enable");
   chk_select_restart: assert property ($changed(ratioSelect) |=> lockPending)
      else $error("no wait after select");
   chk_test_restart: assert property ($fell(testMode) |=> lockPending)
      else $error("no wait after test");
   chk_bank_uniform: assert property (bankAOutputs.level inside {3'h0, 3'h7} &&
      bankBOutputs.level inside {3'h0, 3'h7}) else $error("bank split");
   chk_half_match: assert property (!ratioSelect && selHist == 2'h0 |->
      bankAOutputs.level == bankBOutputs.level) else $error("half rate differs");
   chk_rise_aligned: assert property ($rose(bankAOutputs.level[0]) &&
      ratioSelect == selHist[0] && selHist[0] == selHist[1] |-> $rose(bankBOutputs.level[0]))
      else $error("rises not aligned");
   chk_pending_min: assert property ($fell(lockPending) |-> pendRun >= STAB_CYCLES - 1)
      else $error("wait too short");

   cover property ($fell(lockPending));
   cover property ($rose(bankAOutputs.level[0]) && ratioSelect);
   cover property ($rose(outputEnableN));
endmodule : pll_fanout_checker

bind pll_clock_fanout_select pll_fanout_checker #(.STAB_CYCLES(STAB_CYCLES)) chk_u (
   .ref_clk(ref_clk), .rst(rst), .ratioSelect(ratioSelect), .outputEnableN(outputEnableN),
   .testMode(testMode), .bankAOutputs(bankAOutputs), .bankBOutputs(bankBOutputs),
   .lockPending(lockPending));

// ==== tb/ref_source_model.sv ====
/* Reference source and board feedback wire.
   Assumes bank outputs of the fan-out block. */
`timescale 1ns/1ps

module ref_source_model #(
   parameter int HALF = 20
) (
   input  wire logic                  ref_clk,
   input  wire pll_fanout_pkg::bank_t bankA,
   input  wire pll_fanout_pkg::bank_t bankB,
   output logic                       refOut,
   output logic                       feedOut
);
   int phase = 0;
   initial refOut = 1'b0;
   initial feedOut = 1'b0;
   // Fixed rate and phase
   always @(negedge ref_clk) begin
      phase = (phase == HALF - 1) ? 0 : phase + 1;
      if (phase == 0) refOut = ~refOut;
   end
   // One bank B output wired back; released wire keeps no level
   always @(negedge ref_clk) begin
      feedOut = bankB.drive[0] ? bankB.level[0] : ~feedOut;
   end
endmodule : ref_source_model

// ==== tb/pll_clock_fanout_select_tb.sv ====
/* Self-checking bench for the clock fan-out block.
   Assumes package, checker and reference model compiled first. */
`timescale 1ns/1ps

module pll_clock_fanout_select_tb;
   localparam int STAB = 20;
   logic                  ref_clk, rst, refIn, feedIn, ratioSelect;
   logic                  outputEnableN, testMode, factoryClear, lockPending;
   pll_fanout_pkg::bank_t bankA, bankB;
   int                    num_errors = 0, compares = 0, cyc = 0, n, ra, rb, hi, lo;

   pll_clock_fanout_select #(.STAB_CYCLES(STAB)) dut_u (.ref_clk(ref_clk), .rst(rst),
      .referenceClockIn(refIn), .loopFeedbackIn(feedIn), .ratioSelect(ratioSelect),
      .outputEnableN(outputEnableN), .testMode(testMode), .factoryClear(factoryClear),
      .bankAOutputs(bankA), .bankBOutputs(bankB), .lockPending(lockPending));
   ref_source_model #(.HALF(20)) src_u (.ref_clk(ref_clk), .bankA(bankA), .bankB(bankB),
      .refOut(refIn), .feedOut(feedIn));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic close_out;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         close_out();
      end
   end

   task automatic cmp_bits(input logic [5:0] got, input logic [5:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t %s", $time, what);
      end
   endtask : cmp_bits

   task automatic cmp_range(input int got, input int lo, input int hi, input string what);
      compares++;
      if (got < lo || got > hi) begin
         num_errors++;
         $display("BAD %0t %s %0d", $time, what, got);
      end
   endtask : cmp_range

   task automatic cycles(input int c);
      repeat (c) @(negedge ref_clk);
   endtask : cycles

   task automatic wait_lock;
      n = 0;
      while (lockPending !== 1'b0 && n < 200) begin
         cycles(1);
         n++;
      end
   endtask : wait_lock

   task automatic count_rises(input int c);
      logic pa, pb;
      ra = 0;
      rb = 0;
      pa = bankA.level[0];
      pb = bankB.level[0];
      repeat (c) begin
         cycles(1);
         if (bankA.level[0] === 1'b1 && pa === 1'b0) ra++;
         if (bankB.level[0] === 1'b1 && pb === 1'b0) rb++;
         pa = bankA.level[0];
         pb = bankB.level[0];
      end
   endtask : count_rises

   task automatic run_len(input logic lvl, output int len);
      len = 0;
      while (bankB.level[0] === lvl && len < 300) begin
         cycles(1);
         len++;
      end
   endtask : run_len

   initial begin
      rst = 1'b1;
      ratioSelect = 1'b0;
      outputEnableN = 1'b0;
      testMode = 1'b0;
      factoryClear = 1'b0;
      cycles(2);
      cmp_bits(bankA | bankB, 6'h00, "reset outputs");
      cmp_bits({5'h00, lockPending}, 6'h01, "reset wait");
      cycles(3);
      rst = 1'b0;
      // First reference edge restarts the interval
      while (refIn !== 1'b1) begin
         cycles(1);
      end
      wait_lock();
      cmp_range(n, STAB - 2, STAB + 2, "power-up wait");
      $display("test power-up done");
      outputEnableN = 1'b1;
      cycles(2);
      cmp_bits({bankA.drive, bankB.drive}, 6'h00, "released");
      outputEnableN = 1'b0;
      cycles(2);
      cmp_bits({bankA.drive, bankB.drive}, 6'h3F, "driven");
      cmp_bits({5'h00, lockPending}, 6'h01, "enable wait");
      $display("test enable done");
      cycles(3000);
      cmp_bits({5'h00, lockPending}, 6'h00, "relocked");
      count_rises(800);
      cmp_range(rb, 19, 21, "fed-back bank rate");
      cmp_range(ra, 19, 21, "bank A full rate");
      ratioSelect = 1'b1;
      cycles(2);
      cmp_bits({5'h00, lockPending}, 6'h01, "select wait");
      cycles(200);
      count_rises(800);
      cmp_range(ra, 9, 11, "bank A half rate");
      cmp_range(rb, 19, 21, "bank B fixed rate");
      $display("test select done");
      testMode = 1'b1;
      cycles(200);
      run_len(1'b0, lo);
      run_len(1'b1, hi);
      run_len(1'b0, lo);
      cmp_range(hi, 20, 40, "bypass high time");
      cmp_range(hi - lo, 0, 0, "duty balance");
      testMode = 1'b0;
      cycles(2);
      cmp_bits({5'h00, lockPending}, 6'h01, "test exit wait");
      factoryClear = 1'b1;
      cycles(2);
      cmp_bits({bankA.level, bankB.level}, 6'h00, "clear levels");
      factoryClear = 1'b0;
      cycles(400);
      $display("test bypass done");
      close_out();
   end
endmodule : pll_clock_fanout_select_tb
